// *** pcf_consts.svh ***
// Constants for the program counter and fetch pipeline block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH

// Register byte offsets on the APB slave
`define OFS_PCL        12'h000
`define OFS_LATH       12'h004
`define OFS_LATU       12'h008
`define OFS_CTRL       12'h00c
`define OFS_STATUS     12'h010

// Widths and reset values
`define PC_W           21
`define PC_STEP        21'h000002
`define PC_RST         21'h000000
`define LATH_RST       8'h00
`define LATU_RST       5'h00
`define CTRL_RUN_RST   1'b1

// Phase numbering within one instruction cycle
`define PH_ONE         2'h0
`define PH_TWO         2'h1
`define PH_THREE       2'h2
`define PH_FOUR        2'h3

// Opcode fields of the two-word and flow-changing instructions
`define OP_SECOND_HI   4'hf
`define OP_GOTO        8'hef
`define OP_CALL_HI     7'h76
`define OP_FILE_TO_FILE_MOVE_HI    4'hc
`define OP_LOAD_POINTER_LITERAL_HI     8'hee
`define OP_BRA_HI      4'hd
`define OP_BCC_HI      5'h1c
`define OP_ADD_WORKING_TO_FILE_HI    6'h09
`define OP_PCL_FILE    8'hf9

`endif

// *** pcf_pkg.sv ***
// Types for the program counter and fetch pipeline block.
// Assumes pcf_consts.svh is on the include path.
`include "pcf_consts.svh"

package pcf_pkg;

  // Whole state of the phase generator
  typedef struct packed {
    logic [1:0] cnt;
    logic [3:0] onehot;
  } phase_state_t;

  // Whole state of the counter and pipeline
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0]  lath;
    logic [4:0]  latu;
    logic        run;
    logic [15:0] ir;
    logic        ir_valid;
    logic        fetch_valid;
    logic        kill;
    logic [20:0] pm_addr;
    logic        pm_rd;
    logic        ex_valid;
    logic [15:0] ex_instr;
    logic [11:0] ex_operand;
    logic        dm_read;
    logic        dm_write;
    logic        flush;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } core_state_t;

endpackage

// *** quad_phase_gen.sv ***
// Four-phase instruction cycle generator.
// Assumes pclk stands in for the oscillator input.
`timescale 1ns/1ps

module quad_phase_gen
  import pcf_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic [1:0]      phase,
  output logic [3:0]      phase_onehot
);

  phase_state_t s_q;
  phase_state_t s_d;

  // Divide by four, one-hot copy kept in step with the count
  always_comb begin
    s_d        = s_q;
    s_d.cnt    = s_q.cnt + 2'h1;
    s_d.onehot = {s_q.onehot[2:0], s_q.onehot[3]};
  end

  // Reset lands on phase one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.cnt    <= `PH_ONE;
      s_q.onehot <= 4'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase        = s_q.cnt;
  assign phase_onehot = s_q.onehot;

endmodule

// *** program_counter_fetch_pipeline.sv ***
// Program counter, latch registers and two-stage fetch/execute pipeline.
// Assumes program memory answers pm_rdata within the same instruction
// cycle, and an execute datapath on pclk drives skip, branch and return
// inputs during the execute cycle, stable by phase four.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module program_counter_fetch_pipeline
  import pcf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory
  output logic [20:0]      pm_addr,
  output logic             pm_rd,
  input  wire logic [15:0] pm_rdata,
  // Execute datapath
  input  wire logic [7:0]  working_register,
  input  wire logic        skip_req,
  input  wire logic        cond_taken,
  input  wire logic        ret_valid,
  input  wire logic [20:0] ret_addr,
  output logic             ex_valid,
  output logic [15:0]      ex_instr,
  output logic [11:0]      ex_operand,
  output logic             dm_read,
  output logic             dm_write,
  output logic             flush,
  output logic [3:0]       phase_clk
);

  core_state_t s_q;
  core_state_t s_d;
  logic [1:0]  phase;
  logic [3:0]  phase_onehot;

  // Decode of the word in the instruction register
  logic        is_second;
  logic        is_goto;
  logic        is_call;
  logic        is_two_word;
  logic        is_bra;
  logic        is_bcc;
  logic        is_cjump;
  logic        ir_live;
  logic [20:0] rel_long;
  logic [20:0] rel_short;
  logic [7:0]  pcl_sum;

  // APB decode
  logic        apb_setup_done;
  logic        apb_done;
  logic        addr_hit;
  logic [31:0] rd_mux;

  // Phase generator sits beside the pipeline
  quad_phase_gen u_phase (
    .pclk         (pclk),
    .presetn      (presetn),
    .phase        (phase),
    .phase_onehot (phase_onehot)
  );

  // Instruction classes
  always_comb begin
    is_second   = (s_q.ir[15:12] == `OP_SECOND_HI);
    is_goto     = (s_q.ir[15:8] == `OP_GOTO);
    is_call     = (s_q.ir[15:9] == `OP_CALL_HI);
    is_two_word = is_goto || is_call
                  || (s_q.ir[15:12] == `OP_FILE_TO_FILE_MOVE_HI)
                  || (s_q.ir[15:8] == `OP_LOAD_POINTER_LITERAL_HI);
    is_bra      = (s_q.ir[15:12] == `OP_BRA_HI);
    is_bcc      = (s_q.ir[15:11] == `OP_BCC_HI);
    is_cjump    = (s_q.ir[15:10] == `OP_ADD_WORKING_TO_FILE_HI) && s_q.ir[9]
                  && !s_q.ir[8] && (s_q.ir[7:0] == `OP_PCL_FILE);
    // A lone second word is kept in the pipe but never acts
    ir_live     = s_q.ir_valid && !is_second;
  end

  // Branch targets relative to the word after the branch
  always_comb begin
    // Eleven-bit word offset, sign-extended then doubled
    rel_long  = s_q.pm_addr
                + {{9{s_q.ir[10]}}, s_q.ir[10:0], 1'b0};
    // Eight-bit word offset, sign-extended then doubled
    rel_short = s_q.pm_addr
                + {{12{s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
    // Low byte of the word after the jump plus the working value
    pcl_sum   = s_q.pm_addr[7:0] + working_register;
  end

  // Read data for each mapped offset
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      `OFS_PCL:    rd_mux = {24'h00_0000, s_q.pc[7:1], 1'b0};
      `OFS_LATH:   rd_mux = {24'h00_0000, s_q.lath};
      `OFS_LATU:   rd_mux = {27'h000_0000, s_q.latu};
      `OFS_CTRL:   rd_mux = {31'h0000_0000, s_q.run};
      `OFS_STATUS: rd_mux = {27'h000_0000, phase, s_q.kill,
                             s_q.fetch_valid, s_q.ir_valid};
      default:     addr_hit = 1'b0;
    endcase
  end

  assign apb_setup_done = psel && penable && !s_q.pready;
  assign apb_done       = psel && penable && s_q.pready;

  // Next state of the counter, pipeline and register file
  always_comb begin
    s_d          = s_q;
    s_d.pm_rd    = 1'b0;
    s_d.flush    = 1'b0;
    s_d.dm_read  = 1'b0;
    s_d.dm_write = 1'b0;

    // Fetch stage: issue the address and step the counter in phase one
    if (phase == `PH_ONE) begin
      s_d.pm_addr     = s_q.pc;
      s_d.fetch_valid = s_q.run;
      s_d.pm_rd       = s_q.run;
      if (s_q.run) begin
        s_d.pc = s_q.pc + `PC_STEP;
      end
    end

    // Data memory strobes one cycle early so they leave a flip-flop
    if (phase == `PH_ONE) begin
      s_d.dm_read = s_q.ex_valid;
    end
    if (phase == `PH_THREE) begin
      s_d.dm_write = s_q.ex_valid;
    end

    // Execute stage resolves flow at phase four, overlapping the fetch
    if (phase == `PH_FOUR) begin
      // Word fetched this cycle enters the register; flow may void it
      s_d.ir       = pm_rdata;
      s_d.ir_valid = s_q.fetch_valid && !s_q.kill;
      s_d.kill     = 1'b0;

      if (ir_live && is_two_word) begin
        // Operand rides in the word being fetched right now
        s_d.ex_operand = pm_rdata[11:0];
      end

      if (ir_live && (is_goto || is_call)) begin
        // Word address from both words, bit zero left clear
        s_d.pc       = {pm_rdata[11:0], s_q.ir[7:0], 1'b0};
        s_d.ir_valid = 1'b0;
        s_d.flush    = 1'b1;
      end else if (ir_live && (is_bra || (is_bcc && cond_taken))) begin
        s_d.pc       = is_bra ? rel_long : rel_short;
        s_d.ir_valid = 1'b0;
        s_d.flush    = 1'b1;
      end else if (ir_live && is_cjump) begin
        // Writes the low byte, so the latches fill the upper bytes
        s_d.pc       = {s_q.latu, s_q.lath, pcl_sum[7:1], 1'b0};
        s_d.ir_valid = 1'b0;
        s_d.flush    = 1'b1;
      end else if (ir_live && ret_valid) begin
        // Latches deliberately left alone on the way back
        s_d.pc       = {ret_addr[20:1], 1'b0};
        s_d.ir_valid = 1'b0;
        s_d.flush    = 1'b1;
      end else if (ir_live && skip_req) begin
        // Skipped word is voided; a following second word runs idle
        s_d.ir_valid = 1'b0;
        s_d.flush    = 1'b1;
      end

      // Hand the newly latched word to the execute datapath
      s_d.ex_instr = pm_rdata;
      s_d.ex_valid = s_d.ir_valid && (pm_rdata[15:12] != `OP_SECOND_HI);
    end

    // APB access phase: answer one cycle after the setup cycle ends
    s_d.pready  = apb_setup_done;
    s_d.pslverr = apb_setup_done && (!addr_hit || (paddr[1:0] != 2'h0));
    if (apb_setup_done) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_mux;
    end

    // Register side effects fire only on the completing edge
    if (apb_done && addr_hit) begin
      if (pwrite) begin
        case (paddr)
          `OFS_PCL: begin
            // Computed load: latches supply the two upper bytes
            s_d.pc       = {s_q.latu, s_q.lath, pwdata[7:1], 1'b0};
            s_d.ir_valid = 1'b0;
            s_d.ex_valid = 1'b0;
            // An in-flight fetch from the old counter is stale
            s_d.kill     = (phase != `PH_FOUR);
            s_d.flush    = 1'b1;
          end
          `OFS_LATH: s_d.lath = pwdata[7:0];
          `OFS_LATU: s_d.latu = pwdata[4:0];
          `OFS_CTRL: s_d.run  = pwdata[0];
          default: begin
            s_d.run = s_q.run;
          end
        endcase
      end else if (paddr == `OFS_PCL) begin
        // Reading the low byte snapshots the upper bytes
        s_d.lath = s_q.pc[15:8];
        s_d.latu = s_q.pc[20:16];
      end
    end
  end

  // Single state register; reset empties the pipe at address zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.pc   <= `PC_RST;
      s_q.lath <= `LATH_RST;
      s_q.latu <= `LATU_RST;
      s_q.run  <= `CTRL_RUN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output but phase_clk is a flip-flop of the state register; phase_clk comes from the phase generator
  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign pm_addr    = s_q.pm_addr;
  assign pm_rd      = s_q.pm_rd;
  assign ex_valid   = s_q.ex_valid;
  assign ex_instr   = s_q.ex_instr;
  assign ex_operand = s_q.ex_operand;
  assign dm_read    = s_q.dm_read;
  assign dm_write   = s_q.dm_write;
  assign flush      = s_q.flush;
  assign phase_clk  = phase_onehot;

endmodule

// *** pcf_monitor.sv ***
// Checker on the ports of the counter and fetch pipeline.
// Assumes one clock domain, bound into the pipeline module by the bind below.
`timescale 1ns/1ps
module pcf_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [20:0] pm_addr,
  input wire logic        pm_rd,
  input wire logic        flush,
  input wire logic [3:0]  phase_clk,
  input wire logic        ex_valid,
  input wire logic [15:0] ex_instr,
  input wire logic        dm_read,
  input wire logic        dm_write
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state on every access
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  // Refused access carries no data
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  a_fetch_even: assert property (pm_rd |-> !pm_addr[0])
    else $error("odd fetch");
  // Without a flush between, fetches step by one word
  a_fetch_step: assert property (pm_rd ##1 !flush [*4] ##0 pm_rd
    |-> pm_addr == $past(pm_addr, 4) + 21'h2) else $error("bad step");
  // Gated on a sampled reset release so the held edge is not compared
  a_phase_turn: assert property (presetn |=> $onehot(phase_clk) &&
    phase_clk == {$past(phase_clk[2:0]), $past(phase_clk[3])}) else $error("phase");
  a_fetch_rate: assert property (pm_rd |=> !pm_rd [*3])
    else $error("fetch rate");
  a_ex_hold: assert property ($rose(ex_valid) |=> $stable(ex_instr) [*3])
    else $error("ir moved");
  a_rd_wr: assert property (dm_read |-> ex_valid ##2 dm_write && ex_valid)
    else $error("dm order");
  a_lone_word: assert property (ex_valid |-> ex_instr[15:12] != 4'hf)
    else $error("second word ran");
endmodule

bind program_counter_fetch_pipeline pcf_monitor u_mon (.*);

// *** pm_model.sv ***
// Program memory: sixteen words, address wraps.
// Assumes the block holds pm_addr through each fetch.
`timescale 1ns/1ps
module pm_model (
  input  wire logic [20:0] pm_addr,
  output logic      [15:0] pm_rdata
);
  logic [15:0] mem [16];

  // Word index drops bit 0, low byte at the even address
  assign pm_rdata = mem[pm_addr[4:1]];

  // Goto word 3, then a branch back one word forever
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    mem[1] = 16'hef03;
    mem[2] = 16'hf000;
    mem[3] = 16'hd7ff;
    // Computed jump on the low byte, reached only by a low-byte load
    mem[8] = 16'h26f9;
  end
endmodule

// *** testbench.sv ***
// APB register tasks and fetch address checks.
// Assumes the package, pm_model and the checker compile first.
`timescale 1ns/1ps
`include "pcf_consts.svh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        pm_rd, ex_valid, dm_read, dm_write, flush;
  logic        skip_req = 1'b0, cond_taken = 1'b0, ret_valid = 1'b0;
  logic [7:0]  working_register = 8'h00;
  logic [20:0] ret_addr = 21'h0, pm_addr;
  logic [11:0] paddr, ex_operand;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pm_rdata, ex_instr;
  logic [3:0]  phase_clk;
  int          failures, check_count, fetches, n0;
  logic [20:0] exp_r [6] = '{21'h0, 21'h2, 21'h4, 21'h6, 21'h8, 21'h6};
  logic [20:0] exp_w [2][4] = '{'{21'h031242, 21'h031244, 21'h6, 21'h8},
                                '{21'h031244, 21'h031246, 21'h031248, 21'h031246}};

  program_counter_fetch_pipeline DUT (.*);
  pm_model u_pm (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Counts fetches to show a stopped core stays quiet
  always @(posedge pclk) if (pm_rd === 1'b1) fetches++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Setup, access, hold until pready; one idle edge in front
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fetch(input logic [20:0] e);
    do @(posedge pclk); while (pm_rd !== 1'b1);
    chk(pm_addr, e);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Out of reset: goto over its second word, then branch loop
    foreach (exp_r[i]) fetch(exp_r[i]);
    apb(1'b0, `OFS_LATH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h002, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Stop, load latches, jump via low byte, run again
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `OFS_CTRL, 32'h0);
      apb(1'b1, `OFS_LATH, 32'h12);
      apb(1'b1, `OFS_LATU, 32'h3);
      n0 = fetches;
      apb(1'b1, `OFS_PCL, i ? 32'h45 : 32'h42);
      chk(fetches, n0);
      apb(1'b1, `OFS_CTRL, 32'h1);
      for (int j = 0; j < 4; j++) fetch(exp_w[i][j]);
      if (i == 0) begin
        apb(1'b0, `OFS_LATH, 32'h0);
        chk(rd, 32'h12);
        apb(1'b0, `OFS_PCL, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        apb(1'b0, `OFS_LATH, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `OFS_LATU, 32'h0);
        chk(rd, 32'h0);
      end
    end
    // Computed jump: next low byte plus working value, latches on top
    working_register <= 8'h04;
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_LATH, 32'h12);
    apb(1'b1, `OFS_LATU, 32'h0);
    apb(1'b1, `OFS_PCL, 32'h10);
    apb(1'b1, `OFS_CTRL, 32'h1);
    fetch(21'h001210);
    fetch(21'h001212);
    fetch(21'h001216);
    apb(1'b0, `OFS_LATH, 32'h0);
    chk(rd, 32'h12);
    wrap_up;
  end

  // Tests need under two hundred cycles; 3000 cycles is a hang
  initial begin
    #300000;
    failures++;
    wrap_up;
  end
endmodule
